// ---- core/acc_core.sv ----
// Comparator control, result reporting and edge flag logic with a Wishbone slave
`timescale 1ns/1ns
`include "acc_regs.svh"

// What this block does
// - Comparator works only while its on bit seven is set.
// - Raw result high when positive input exceeds negative input.
// - Invert bit four flips the result before reporting or routing.
// - Read-only bit six shows the polarity-adjusted result.
// - Mirror register holds comparator two in bit one, one in bit zero.
// - Bit one enables input hysteresis.
// - Sync bit zero latches result on falling timer clock edge.
// - Latch on falling timer edge so it never meets counting.
// - Sync clear forwards result to timers and pin directly.
// - Internal result sampled every cycle; external result latched only with sync set.
// - Rise enable sets the flag on a low-to-high result change.
// - Fall enable sets the flag on a high-to-low result change.
// - An edge in the clearing cycle wins and leaves the flag set.
// - Edges act on the inverted, enable-gated result.
// - Negative select: four pins, two open, fixed reference, ground.
// - Positive select: two pins, three open, DAC, fixed reference, ground.
// - Unused bit two of control reads one; other unused bits zero.
// - Rising result edge triggers conversion.
// - A disabled comparator disconnects all its inputs.
module acc_core
   import acc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [1:0] raw_result_i,
   input wire logic [1:0] timer_clk_i,
   output logic [1:0] comparator_on_o,
   output logic [1:0] hysteresis_on_o,
   output logic [5:0] inv_input_select_o,
   output logic [5:0] noninv_input_select_o,
   output logic [1:0] ext_result_o,
   output logic [1:0] adc_trigger_o,
   output logic [1:0] compare_irq_flag_o
);
   acc_state_t s;
   acc_state_t next_s;

   // Register hits per comparator; index 0 is the first comparator
   function automatic logic hit_con0(input logic [7:0] a, input int unsigned i);
      logic h;
      if (i == 0) begin
         h = (a == `ACC_OFS_CON0_1);
      end else begin
         h = (a == `ACC_OFS_CON0_2);
      end
      return h;
   endfunction

   function automatic logic hit_con1(input logic [7:0] a, input int unsigned i);
      logic h;
      if (i == 0) begin
         h = (a == `ACC_OFS_CON1_1);
      end else begin
         h = (a == `ACC_OFS_CON1_2);
      end
      return h;
   endfunction

   function automatic logic hit_nch(input logic [7:0] a, input int unsigned i);
      logic h;
      if (i == 0) begin
         h = (a == `ACC_OFS_NCH_1);
      end else begin
         h = (a == `ACC_OFS_NCH_2);
      end
      return h;
   endfunction

   function automatic logic hit_pch(input logic [7:0] a, input int unsigned i);
      logic h;
      if (i == 0) begin
         h = (a == `ACC_OFS_PCH_1);
      end else begin
         h = (a == `ACC_OFS_PCH_2);
      end
      return h;
   endfunction

   // Byte images of two- and three-bit fields; upper bits read as zero
   function automatic logic [7:0] pad2(input logic [1:0] v);
      return {6'h00, v};
   endfunction

   function automatic logic [7:0] pad3(input logic [2:0] v);
      return {5'h00, v};
   endfunction

   // Bit two is hard-wired high, the other unused bits read zero
   function automatic logic [7:0] con0_image(input acc_cfg_t c, input logic res);
      logic [7:0] v;
      v = 8'h00;
      v[`ACC_BIT_ON] = c.on;
      v[`ACC_BIT_RESULT] = res;
      v[`ACC_BIT_INVERT] = c.invert;
      v[`ACC_BIT_ONE] = 1'b1;
      v[`ACC_BIT_HYS] = c.hysteresis_on;
      v[`ACC_BIT_SYNC] = c.sync;
      return v;
   endfunction

   // Adjusted, enable-gated result as seen by software and edge logic
   function automatic logic adjust(input acc_cfg_t c, input logic raw);
      return c.on & (raw ^ c.invert);
   endfunction

   // One-cycle pulse on a low-to-high step between two samples
   function automatic logic rise_of(input logic cur, input logic old);
      return cur & ~old;
   endfunction

   // Enabled edge of the reported result; the detector runs even while disabled
   function automatic logic edge_seen(input acc_cfg_t c, input logic cur, input logic old);
      logic up;
      logic down;
      up = rise_of(cur, old);
      down = rise_of(old, cur);
      return (c.rise_en & up) | (c.fall_en & down);
   endfunction

   // Flag update; the set term is applied last so it wins over a clear
   function automatic logic flag_next(input logic old, input logic clr, input logic set);
      logic f;
      f = old;
      if (clr) begin
         f = 1'b0;
      end
      if (set) begin
         f = 1'b1;
      end
      return f;
   endfunction

   // Timer-side result: the falling-edge latch when synchronised, else direct
   function automatic logic ext_pick(input logic sync, input logic latched, input logic direct);
      logic e;
      if (sync) begin
         e = latched;
      end else begin
         e = direct;
      end
      return e;
   endfunction

   // Negative input route; both open codes collapse to one open code
   function automatic logic [2:0] neg_route(input logic on, input logic [2:0] v);
      logic [2:0] r;
      if (!on) begin
         r = `ACC_SEL_NONE;
      end else if (v == 3'h4 || v == 3'h5) begin
         r = 3'h4;
      end else begin
         r = v;
      end
      return r;
   endfunction

   // Positive input route; the three open codes collapse to one open code
   function automatic logic [2:0] pos_route(input logic on, input logic [2:0] v);
      logic [2:0] r;
      if (!on) begin
         r = `ACC_SEL_NONE;
      end else if (v >= 3'h2 && v <= 3'h4) begin
         r = 3'h2;
      end else begin
         r = v;
      end
      return r;
   endfunction

   // Apply one register write to a comparator's configuration
   function automatic acc_cfg_t cfg_write(input acc_cfg_t c, input logic [7:0] a,
                                          input logic [7:0] d, input int unsigned i);
      acc_cfg_t n;
      n = c;
      if (hit_con0(a, i)) begin
         n.on = d[`ACC_BIT_ON];
         n.invert = d[`ACC_BIT_INVERT];
         n.hysteresis_on = d[`ACC_BIT_HYS];
         n.sync = d[`ACC_BIT_SYNC];
      end else if (hit_con1(a, i)) begin
         n.rise_en = d[`ACC_BIT_RISE];
         n.fall_en = d[`ACC_BIT_FALL];
      end else if (hit_nch(a, i)) begin
         n.inv_sel = d[2:0];
      end else if (hit_pch(a, i)) begin
         n.noninv_sel = d[2:0];
      end
      return n;
   endfunction

   // Read image of one comparator's registers; zero when no register is hit
   function automatic logic [7:0] cfg_image(input acc_cfg_t c, input logic [7:0] a,
                                            input int unsigned i, input logic res);
      logic [7:0] v;
      v = 8'h00;
      if (hit_con0(a, i)) begin
         v = con0_image(c, res);
      end else if (hit_con1(a, i)) begin
         v = pad2({c.rise_en, c.fall_en});
      end else if (hit_nch(a, i)) begin
         v = pad3(c.inv_sel);
      end else if (hit_pch(a, i)) begin
         v = pad3(c.noninv_sel);
      end
      return v;
   endfunction

   // Bus qualifiers and per-comparator helper terms
   logic access;
   logic wr_access;
   logic rd_access;
   logic [1:0] adj_now;
   logic [1:0] tclk_fell;
   logic [1:0] edge_hit;
   logic [1:0] clear_req;
   logic [7:0] rd;

   // One access per request; the pending ack blocks a second take
   always_comb begin
      access = cyc_i & stb_i & ~s.ack;
      wr_access = access & we_i & sel_i[0];
      rd_access = access & ~we_i;
   end

   // Latch only on a falling timer clock edge, away from the rising count edge
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         // Raw result comes from the analog comparator, high when plus exceeds minus
         adj_now[i] = adjust(s.cfg[i], raw_result_i[i]);
         tclk_fell[i] = s.tclk_prev[i] & ~timer_clk_i[i];
         edge_hit[i] = edge_seen(s.cfg[i], s.sampled[i], s.prev[i]);
         clear_req[i] = wr_access & (adr_i == `ACC_OFS_IRQ_FLAG) & ~dat_i[i];
      end
   end

   // Read mux; the two comparators never share an offset, so their images combine
   always_comb begin
      rd = 8'h00;
      if (adr_i == `ACC_OFS_MIRROR) begin
         rd = pad2(s.sampled);
      end else if (adr_i == `ACC_OFS_IRQ_FLAG) begin
         rd = pad2(s.irq_flag);
      end else begin
         rd = cfg_image(s.cfg[0], adr_i, 0, s.sampled[0]) |
              cfg_image(s.cfg[1], adr_i, 1, s.sampled[1]);
      end
   end

   // Result path samples every cycle; config and flags follow the bus.
   // Edges are taken from two registered samples, so a flag sets two edges
   // after the analog input moves; a coincident clear loses to the set.
   always_comb begin
      next_s = s;
      next_s.sampled = adj_now;
      next_s.prev = s.sampled;
      next_s.tclk_prev = timer_clk_i;
      for (int i = 0; i < 2; i++) begin
         if (tclk_fell[i]) begin
            next_s.sync_out[i] = adj_now[i];
         end
         next_s.ext_out[i] = ext_pick(s.cfg[i].sync, next_s.sync_out[i], adj_now[i]);
         next_s.adc_trig[i] = rise_of(s.sampled[i], s.prev[i]);
         if (wr_access) begin
            next_s.cfg[i] = cfg_write(s.cfg[i], adr_i, dat_i[7:0], i);
         end
         next_s.irq_flag[i] = flag_next(s.irq_flag[i], clear_req[i], edge_hit[i]);
      end
      next_s.ack = access;
      if (rd_access) begin
         next_s.dat = {24'h000000, rd};
      end else if (access) begin
         next_s.dat = 32'h00000000;
      end
      if (rst_i) begin
         next_s = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      s <= next_s;
   end

   // Enable and hysteresis go out registered so the analog side sees no glitch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         comparator_on_o <= 2'b00;
         hysteresis_on_o <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            comparator_on_o[i] <= next_s.cfg[i].on;
            hysteresis_on_o[i] <= next_s.cfg[i].on & next_s.cfg[i].hysteresis_on;
         end
      end
   end

   // Input routes change in the same cycle as the enable they depend on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inv_input_select_o <= 6'h00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            inv_input_select_o[i*3 +: 3] <=
               neg_route(next_s.cfg[i].on, next_s.cfg[i].inv_sel);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         noninv_input_select_o <= 6'h00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            noninv_input_select_o[i*3 +: 3] <=
               pos_route(next_s.cfg[i].on, next_s.cfg[i].noninv_sel);
         end
      end
   end

   // These outputs are plain wires from state flip-flops
   always_comb begin
      dat_o = s.dat;
      ack_o = s.ack;
      ext_result_o = s.ext_out;
      adc_trigger_o = s.adc_trig;
      compare_irq_flag_o = s.irq_flag;
   end
endmodule

// ---- common/acc_regs.svh ----
// Register offsets, field positions and input select codes of the comparator control block
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
`define ACC_OFS_CON0_1 8'h00
`define ACC_OFS_CON1_1 8'h04
`define ACC_OFS_NCH_1 8'h08
`define ACC_OFS_PCH_1 8'h0C
`define ACC_OFS_CON0_2 8'h10
`define ACC_OFS_CON1_2 8'h14
`define ACC_OFS_NCH_2 8'h18
`define ACC_OFS_PCH_2 8'h1C
`define ACC_OFS_MIRROR 8'h20
`define ACC_OFS_IRQ_FLAG 8'h24
`define ACC_BIT_ON 7
`define ACC_BIT_RESULT 6
`define ACC_BIT_INVERT 4
`define ACC_BIT_ONE 2
`define ACC_BIT_HYS 1
`define ACC_BIT_SYNC 0
`define ACC_BIT_RISE 1
`define ACC_BIT_FALL 0
`define ACC_SEL_AGND 3'h7
`define ACC_SEL_FIXREF 3'h6
`define ACC_SEL_DAC 3'h5
`define ACC_SEL_NONE 3'h0
`endif

// ---- common/acc_pkg.sv ----
// Types of the comparator control block
package acc_pkg;
   typedef struct packed {
      logic on;
      logic invert;
      logic hysteresis_on;
      logic sync;
      logic rise_en;
      logic fall_en;
      logic [2:0] inv_sel;
      logic [2:0] noninv_sel;
   } acc_cfg_t;

   typedef struct packed {
      acc_cfg_t [1:0] cfg;
      logic [1:0] sampled;
      logic [1:0] prev;
      logic [1:0] tclk_prev;
      logic [1:0] sync_out;
      logic [1:0] irq_flag;
      logic [1:0] adc_trig;
      logic [1:0] ext_out;
      logic ack;
      logic [31:0] dat;
   } acc_state_t;
endpackage

// ---- dv/acc_core_props.sv ----
// Port-level checks of the comparator control block
`timescale 1ns/1ns
`include "acc_regs.svh"
module acc_core_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic [1:0] comparator_on_o,
   input wire logic [1:0] hysteresis_on_o,
   input wire logic [5:0] inv_input_select_o,
   input wire logic [5:0] noninv_input_select_o,
   input wire logic [1:0] adc_trigger_o,
   input wire logic [1:0] compare_irq_flag_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_ANSWER: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("access not answered in one cycle");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   AST_ACK_IDLE: assert property (!(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without request");
   AST_DAT_UPPER: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   AST_HYS_ON: assert property ((hysteresis_on_o & ~comparator_on_o) == 2'h0)
      else $error("hysteresis on a disabled comparator");
   AST_OFF_OPEN: assert property (!comparator_on_o[0] |->
      inv_input_select_o[2:0] == 3'h0 && noninv_input_select_o[2:0] == 3'h0)
      else $error("disabled comparator keeps an input");
   AST_SEL_MAP: assert property (inv_input_select_o[2:0] != 3'h5 &&
      !(noninv_input_select_o[2:0] inside {3'h3, 3'h4}))
      else $error("open channel code not folded");
   AST_TRIG_PULSE: assert property (adc_trigger_o[0] |=> !adc_trigger_o[0])
      else $error("trigger longer than one cycle");
   AST_FLAG_STICKY: assert property ($fell(compare_irq_flag_o[0]) && !$past(rst_i) |->
      $past(cyc_i && stb_i && we_i && sel_i[0] && !dat_i[0] && adr_i == `ACC_OFS_IRQ_FLAG))
      else $error("flag cleared without a write");
endmodule
bind acc_core acc_core_props props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .comparator_on_o(comparator_on_o), .hysteresis_on_o(hysteresis_on_o),
   .inv_input_select_o(inv_input_select_o), .noninv_input_select_o(noninv_input_select_o),
   .adc_trigger_o(adc_trigger_o), .compare_irq_flag_o(compare_irq_flag_o));

// ---- dv/acc_analog.sv ----
// Analog side model: two input voltage pairs and a divided timer clock
`timescale 1ns/1ns
module acc_analog (
   input wire logic clk_i,
   input wire logic [15:0] vp_i,
   input wire logic [15:0] vn_i,
   output logic [1:0] raw_result_o,
   output logic [1:0] timer_clk_o
);
   logic [1:0] div = 2'h0;
   // Timer clock as after a prescaler of four
   always @(posedge clk_i) div <= div + 2'h1;
   assign timer_clk_o = {2{div[1]}};
   assign raw_result_o = {vp_i[15:8] > vn_i[15:8], vp_i[7:0] > vn_i[7:0]};
endmodule

// ---- dv/analog_comparator_control_test.sv ----
// Self-checking bench for the comparator control block
`timescale 1ns/1ns
`include "acc_regs.svh"
module analog_comparator_control_test;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic [15:0] vp = 16'h0000, vn = 16'h8080;
   logic ack_o;
   logic [1:0] raw, tclk, on_o, hys_o, ext_o, trig_o, flag_o;
   logic [5:0] inv_o, non_o;
   logic [7:0] ofs [6] = '{`ACC_OFS_CON0_1, `ACC_OFS_CON1_1, `ACC_OFS_NCH_1,
      `ACC_OFS_PCH_1, `ACC_OFS_MIRROR, 8'h30};
   int n_mismatch = 0, samples_checked = 0;
   int n_trig0 = 0, n_trig1 = 0;
   always @(posedge clk_i) begin
      if (trig_o[0] === 1'b1) n_trig0++;
      if (trig_o[1] === 1'b1) n_trig1++;
   end
   always #20 clk_i = ~clk_i;
   acc_analog model (.clk_i(clk_i), .vp_i(vp), .vn_i(vn), .raw_result_o(raw),
      .timer_clk_o(tclk));
   acc_core uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .raw_result_i(raw), .timer_clk_i(tclk), .comparator_on_o(on_o),
      .hysteresis_on_o(hys_o), .inv_input_select_o(inv_o), .noninv_input_select_o(non_o),
      .ext_result_o(ext_o), .adc_trigger_o(trig_o), .compare_irq_flag_o(flag_o));
   task automatic conclude();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic cycle; only the watchdog ends a wait for a silent slave
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      check(rd, {24'h0, e});
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (ofs[i]) rchk(ofs[i], (i == 0) ? 8'h04 : 8'h00);
      vp <= 16'h9090;
      wb(1'b1, `ACC_OFS_CON1_1, 8'h02);
      wb(1'b1, `ACC_OFS_CON0_1, 8'h80);
      repeat (4) @(posedge clk_i);
      rchk(`ACC_OFS_CON0_1, 8'hC4);
      check({30'h0, flag_o}, 32'h1);
      wb(1'b1, `ACC_OFS_MIRROR, 8'hFF);
      rchk(`ACC_OFS_MIRROR, 8'h01);
      wb(1'b1, `ACC_OFS_CON0_1, 8'hB2);
      rchk(`ACC_OFS_CON0_1, 8'h96);
      check({30'h0, hys_o}, 32'h1);
      wb(1'b1, `ACC_OFS_CON1_1, 8'h01);
      wb(1'b1, `ACC_OFS_IRQ_FLAG, 8'h00);
      vp <= 16'h9000;
      repeat (4) @(posedge clk_i);
      check({30'h0, flag_o}, 32'h0);
      vp <= 16'h9090;
      repeat (4) @(posedge clk_i);
      check({30'h0, flag_o}, 32'h1);
      sel_i <= 4'h0;
      wb(1'b1, `ACC_OFS_CON1_1, 8'h03);
      sel_i <= 4'hF;
      rchk(`ACC_OFS_CON1_1, 8'h01);
      wb(1'b1, `ACC_OFS_CON0_2, 8'h80);
      repeat (4) @(posedge clk_i);
      rchk(`ACC_OFS_MIRROR, 8'h02);
      check({31'h0, ext_o[1]}, 32'h1);
      check({30'h0, on_o}, 32'h3);
      for (int s = 0; s < 8; s++) begin
         wb(1'b1, `ACC_OFS_NCH_1, s[7:0]);
         wb(1'b1, `ACC_OFS_PCH_1, s[7:0]);
         rchk(`ACC_OFS_NCH_1, s[7:0]);
         check({29'h0, inv_o[2:0]}, (s == 5) ? 32'h4 : s);
         check({29'h0, non_o[2:0]}, (s == 3 || s == 4) ? 32'h2 : s);
      end
      wb(1'b1, `ACC_OFS_CON0_2, 8'h81);
      @(posedge tclk[1]);
      @(posedge clk_i);
      vp <= 16'h0090;
      repeat (2) @(posedge clk_i);
      check({31'h0, ext_o[1]}, 32'h1);
      repeat (12) @(posedge clk_i);
      check({31'h0, ext_o[1]}, 32'h0);
      wb(1'b1, `ACC_OFS_CON0_1, 8'h00);
      repeat (2) @(posedge clk_i);
      check({26'h0, non_o[2:0], inv_o[2:0]}, 32'h0);
      check({30'h0, on_o}, 32'h2);
      check(n_trig0, 32'h2);
      check(n_trig1, 32'h1);
      conclude();
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      n_mismatch++;
      conclude();
   end
endmodule
